//--- design/lpc_regs.sv
// Indicator and transceiver control registers on classic Wishbone
`timescale 1ns/1ps
`include "lpc_consts.svh"
module lpc_regs #(
  parameter int unsigned CLK_HZ = `LPC_CLK_HZ,
  parameter int unsigned STRETCH_MS = `LPC_STRETCH_MS
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic extended_mode_i,
  input wire lpc_pkg::lpc_strap_s strap_i,
  input wire lpc_pkg::lpc_neg_s neg_i,
  input wire logic link_event_i,
  output logic link_indicator_pin_o,
  output logic activity_indicator_o,
  output logic auto_crossover_o,
  output logic force_crossover_o,
  output logic pause_rx_o,
  output logic pause_tx_o,
  output logic [4:0] mgmt_addr_o,
  output logic irq_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] in_m_q, in_s_q;
  logic [7:0] st_m_q, st_s_q;
  logic [7:0] ng_m_q, ng_s_q;
  lpc_pkg::lpc_strap_s strap;
  lpc_pkg::lpc_neg_s neg;
  logic ext_mode, link_ev;

  always_ff @(posedge sys_clk_i) begin
    in_m_q <= {extended_mode_i, link_event_i};
    in_s_q <= in_m_q;
    st_m_q <= strap_i;
    st_s_q <= st_m_q;
    ng_m_q <= neg_i;
    ng_s_q <= ng_m_q;
  end

  assign ext_mode = in_s_q[1];
  assign link_ev = in_s_q[0];
  assign strap = lpc_pkg::lpc_strap_s'(st_s_q);
  assign neg = lpc_pkg::lpc_neg_s'(ng_s_q);

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  logic [2:0] rel_q, rel_d;
  logic latch;

  always_comb begin
    rel_d = rel_q;
    if (rel_q != 3'h3) begin
      rel_d = rel_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rel_q <= 3'h0;
    end else begin
      rel_q <= rel_d;
    end
  end

  assign latch = (rel_q == 3'h2);

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] sel, input logic [15:0] wm);
    logic [15:0] lane;
    lane = {{8{sel[1]}}, {8{sel[0]}}} & wm;
    merge = (old & ~lane) | (wd & lane);
  endfunction

  function automatic logic [3:0] decode(input logic [7:0] i);
    decode = 4'h0;
    case (i)
      `LPC_IDX_IND_CTRL: decode = 4'h1;
      `LPC_IDX_PHY_CTRL: decode = 4'h2;
      `LPC_IDX_STATUS: decode = 4'h4;
      `LPC_IDX_MASK: decode = 4'h8;
      default: decode = 4'h0;
    endcase
  endfunction

  lpc_pkg::lpc_bus_e bus_q, bus_d;
  logic req, wr, rd;
  logic [7:0] idx;
  logic [3:0] dec;
  logic hit;
  logic [31:0] rdat_d, rdat_q;
  logic ack_d, err_d, ack_q, err_q;

  assign req = wb_cyc_i & wb_stb_i & (bus_q == lpc_pkg::LPC_IDLE);
  assign idx = wb_adr_i[9:2];
  assign dec = decode(idx);
  assign hit = |dec;
  // Writes commit at the edge that samples ack
  assign wr = ack_q & wb_cyc_i & wb_stb_i & wb_we_i;
  assign rd = req & ~wb_we_i & hit;

  always_comb begin
    bus_d = bus_q;
    ack_d = 1'b0;
    err_d = 1'b0;
    case (bus_q)
      lpc_pkg::LPC_IDLE: begin
        if (req) begin
          bus_d = lpc_pkg::LPC_ACK;
          ack_d = hit;
          err_d = ~hit;
        end
      end
      lpc_pkg::LPC_ACK: bus_d = lpc_pkg::LPC_IDLE;
      default: bus_d = lpc_pkg::LPC_IDLE;
    endcase
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [15:0] ind_q, ind_d, phy_q, phy_d;
  logic [4:0] addr_q, addr_d;

  always_comb begin
    ind_d = ind_q;
    phy_d = phy_q;
    addr_d = addr_q;
    if (latch) begin
      ind_d[`LPC_IND_POL] = ext_mode ? strap.link_pol : 1'b0;
      phy_d[`LPC_PHY_AUTOX] = ext_mode ? strap.autox : 1'b1;
      phy_d[`LPC_PHY_FORCEX] = (ext_mode & ~strap.autox) ? strap.forcex : 1'b0;
      addr_d = strap.phy_addr;
    end else if (wr && dec[0]) begin
      ind_d = merge(ind_q, wb_dat_i[15:0], wb_sel_i[1:0], `LPC_IND_WMASK);
    end else if (wr && dec[1]) begin
      phy_d = merge(phy_q, wb_dat_i[15:0], wb_sel_i[1:0], `LPC_PHY_WMASK);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ind_q <= `LPC_IND_RESET;
      phy_q <= `LPC_PHY_RESET;
      addr_q <= 5'h0;
    end else begin
      ind_q <= ind_d;
      phy_q <= phy_d;
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------
  // Negotiation status
  // ----------------------------------------
  logic prx, ptx, link_fd;
  logic [2:0] pst_d, pst_q;

  always_comb begin
    prx = 1'b0;
    ptx = 1'b0;
    if (neg.aneg_done && neg.full_duplex) begin
      // Pause resolution from local and partner symmetric and asymmetric bits
      if (neg.local_pause[0] && neg.partner_pause[0]) begin
        prx = 1'b1;
        ptx = 1'b1;
      end else if (neg.local_pause == 2'h3 && neg.partner_pause == 2'h2) begin
        prx = 1'b1;
      end else if (neg.local_pause == 2'h2 && neg.partner_pause == 2'h3) begin
        ptx = 1'b1;
      end
    end
    link_fd = neg.link_up & neg.speed_100 & neg.full_duplex & neg.aneg_done;
    pst_d = {prx, ptx, link_fd};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pst_q <= 3'h0;
    end else begin
      pst_q <= pst_d;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic [2:0] sts_q, sts_d, msk_q, msk_d, evt;

  assign evt = pst_d ^ pst_q;

  always_comb begin
    sts_d = sts_q;
    msk_d = msk_q;
    if (rd && dec[2]) begin
      sts_d = 3'h0;
    end
    // Clear on read keeps an event of the same edge
    sts_d = sts_d | evt;
    if (wr && dec[3] && wb_sel_i[0]) begin
      msk_d = wb_dat_i[2:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sts_q <= 3'h0;
      msk_q <= 3'h0;
    end else begin
      sts_q <= sts_d;
      msk_q <= msk_d;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [15:0] phy_view;

  assign phy_view = {phy_q[15:14], pst_q, 3'h0, phy_q[7:5], addr_q};

  always_comb begin
    rdat_d = 32'h0;
    case (idx)
      `LPC_IDX_IND_CTRL: rdat_d = {16'h0, ind_q};
      `LPC_IDX_PHY_CTRL: rdat_d = {16'h0, phy_view};
      `LPC_IDX_STATUS: rdat_d = {29'h0, sts_q};
      `LPC_IDX_MASK: rdat_d = {29'h0, msk_q};
      default: rdat_d = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bus_q <= lpc_pkg::LPC_IDLE;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      bus_q <= bus_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdat_q <= rd ? rdat_d : rdat_q;
    end
  end

  // ----------------------------------------
  // Indicator outputs
  // ----------------------------------------
  logic blink, stretched, link_lvl, led_q, led_d;

  lpc_blinker #(
    .CLK_HZ(CLK_HZ),
    .STRETCH_MS(STRETCH_MS)
  ) u_blink (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .rate_i(ind_q[`LPC_IND_BLINK_HI:`LPC_IND_BLINK_LO]),
    .bypass_i(phy_q[`LPC_PHY_BYPASS]),
    .event_i(link_ev),
    .blink_o(blink),
    .stretched_o(stretched)
  );

  always_comb begin
    link_lvl = pst_q[0] ^ ~ind_q[`LPC_IND_POL];
    led_d = ind_q[`LPC_IND_DRIVE] ? ind_q[`LPC_IND_FORCE] : link_lvl;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      led_q <= 1'b1;
    end else begin
      led_q <= led_d;
    end
  end

  assign link_indicator_pin_o = led_q;
  assign activity_indicator_o = stretched & blink;
  assign auto_crossover_o = phy_q[`LPC_PHY_AUTOX];
  assign force_crossover_o = phy_q[`LPC_PHY_FORCEX];
  assign pause_rx_o = pst_q[2];
  assign pause_tx_o = pst_q[1];
  assign mgmt_addr_o = addr_q;
  assign irq_o = |(sts_q & msk_q);
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
endmodule

//--- design/lpc_consts.svh
// Constants for the indicator and transceiver control register block
`ifndef LPC_CONSTS_SVH
`define LPC_CONSTS_SVH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define LPC_IDX_IND_CTRL 8'h18
`define LPC_IDX_PHY_CTRL 8'h19
`define LPC_IDX_STATUS 8'h1c
`define LPC_IDX_MASK 8'h1d
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LPC_IND_BLINK_HI 10
`define LPC_IND_BLINK_LO 9
`define LPC_IND_POL 7
`define LPC_IND_DRIVE 4
`define LPC_IND_FORCE 1
`define LPC_PHY_AUTOX 15
`define LPC_PHY_FORCEX 14
`define LPC_PHY_PRX 13
`define LPC_PHY_PTX 12
`define LPC_PHY_LINK 11
`define LPC_PHY_BYPASS 7
`define LPC_PHY_LEDCFG 5
// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define LPC_IND_RESET 16'h0400
`define LPC_IND_WMASK 16'h0692
`define LPC_PHY_RESET 16'h8000
`define LPC_PHY_WMASK 16'hc0a0
`define LPC_BLINK_RESET 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define LPC_CLK_HZ 200000000
`define LPC_BLINK_MS0 50
`define LPC_BLINK_MS1 100
`define LPC_BLINK_MS2 200
`define LPC_BLINK_MS3 500
`define LPC_STRETCH_MS 50
`endif

//--- design/lpc_pkg.sv
// Types for the indicator and transceiver control register block
package lpc_pkg;
  typedef struct packed {
    logic [4:0] phy_addr;
    logic link_pol;
    logic autox;
    logic forcex;
  } lpc_strap_s;
  typedef struct packed {
    logic full_duplex;
    logic speed_100;
    logic aneg_done;
    logic link_up;
    logic [1:0] local_pause;
    logic [1:0] partner_pause;
  } lpc_neg_s;
  typedef enum logic [1:0] {
    LPC_IDLE,
    LPC_ACK
  } lpc_bus_e;
endpackage

//--- design/lpc_blinker.sv
// Indicator blink timer and pulse stretcher
`timescale 1ns/1ps
`include "lpc_consts.svh"
module lpc_blinker #(
  parameter int unsigned CLK_HZ = `LPC_CLK_HZ,
  parameter int unsigned STRETCH_MS = `LPC_STRETCH_MS
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] rate_i,
  input wire logic bypass_i,
  input wire logic event_i,
  output logic blink_o,
  output logic stretched_o
);
  localparam longint unsigned CPM = longint'(CLK_HZ) / 64'd1000;
  localparam logic [31:0] P0 = 32'(CPM * `LPC_BLINK_MS0);
  localparam logic [31:0] P1 = 32'(CPM * `LPC_BLINK_MS1);
  localparam logic [31:0] P2 = 32'(CPM * `LPC_BLINK_MS2);
  localparam logic [31:0] P3 = 32'(CPM * `LPC_BLINK_MS3);
  localparam logic [31:0] PS = 32'(CPM * STRETCH_MS);

  function automatic logic [31:0] period(input logic [1:0] r);
    case (r)
      2'h0: period = P0;
      2'h1: period = P1;
      2'h2: period = P2;
      default: period = P3;
    endcase
  endfunction

  logic [31:0] cnt_q, cnt_d, st_q, st_d;
  logic blink_q, blink_d;

  always_comb begin
    cnt_d = cnt_q + 32'h1;
    blink_d = blink_q;
    if (cnt_q + 32'h1 >= period(rate_i)) begin
      cnt_d = 32'h0;
      blink_d = ~blink_q;
    end
    st_d = (st_q != 32'h0) ? st_q - 32'h1 : 32'h0;
    if (event_i) begin
      st_d = PS;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
      blink_q <= 1'b0;
      st_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
      blink_q <= blink_d;
      st_q <= st_d;
    end
  end

  assign blink_o = blink_q;
  assign stretched_o = bypass_i ? event_i : (event_i | (st_q != 32'h0));
endmodule

//--- tb/lpc_regs_properties.sv
// Port checker for the control register block
`timescale 1ns/1ps
`include "lpc_consts.svh"
module lpc_regs_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire lpc_pkg::lpc_strap_s strap_i,
  input wire lpc_pkg::lpc_neg_s neg_i,
  input wire logic pause_rx_o,
  input wire logic pause_tx_o,
  input wire logic [4:0] mgmt_addr_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic req;
  logic hit;
  logic [3:0] age_q;
  logic [3:0] age_d;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign hit = wb_adr_i[9:2] inside {`LPC_IDX_IND_CTRL, `LPC_IDX_PHY_CTRL,
    `LPC_IDX_STATUS, `LPC_IDX_MASK};
  assign age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
  always_ff @(posedge sys_clk_i) begin
    age_q <= rst_n_i ? age_d : 4'h0;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_mapped_ack: assert property (req && hit |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_unmapped_err: assert property (req && !hit |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_quiet_bus: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_half_pause: assert property ((!neg_i.full_duplex) [*5] |-> !pause_rx_o && !pause_tx_o)
    else $error("pause outside full duplex");
  a_sym_pause: assert property ((neg_i.full_duplex && neg_i.aneg_done && neg_i.local_pause[0]
    && neg_i.partner_pause[0]) [*5] |-> pause_rx_o && pause_tx_o)
    else $error("symmetric pause not resolved");
  a_asym_rx: assert property ((neg_i.full_duplex && neg_i.aneg_done && neg_i.local_pause == 2'h3
    && neg_i.partner_pause == 2'h2) [*5] |-> pause_rx_o && !pause_tx_o)
    else $error("asymmetric pause wrong");
  a_addr_strap: assert property (age_q > 4'h6 |-> mgmt_addr_o == strap_i.phy_addr)
    else $error("address not strap value");
endmodule
bind lpc_regs lpc_regs_properties u_props (.sys_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_adr_i, .wb_ack_o, .wb_err_o, .strap_i, .neg_i, .pause_rx_o, .pause_tx_o, .mgmt_addr_o);

//--- tb/lpc_regs_tb.sv
// Self-checking bench for the control register block
`timescale 1ns/1ps
`include "lpc_consts.svh"
module lpc_regs_tb;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [9:0] adr = 10'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic ev = 1'h0;
  logic xm = 1'h0;
  lpc_pkg::lpc_strap_s strap = 8'h5f;
  lpc_pkg::lpc_neg_s neg = 8'h00;
  logic [31:0] rdat;
  logic ack;
  logic err;
  logic pin;
  logic act;
  logic ax;
  logic fx;
  logic prx;
  logic ptx;
  logic [4:0] maddr;
  logic irq;
  logic [31:0] q;
  logic e;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int ms[4] = '{`LPC_BLINK_MS0, `LPC_BLINK_MS1, `LPC_BLINK_MS2, `LPC_BLINK_MS3};
  logic [15:0] pv[5] = '{16'h0000, 16'h0080, 16'h0010, 16'h0012, 16'h0092};
  logic [4:0] pe = 5'h19;
  logic [7:0] nv[6] = '{8'hf5, 8'hfe, 8'hfb, 8'hff, 8'hb5, 8'h75};
  logic [2:0] nx[6] = '{3'h7, 3'h5, 3'h3, 3'h7, 3'h6, 3'h0};
  lpc_regs #(.CLK_HZ(1000)) DUT (.sys_clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .extended_mode_i(xm), .strap_i(strap), .neg_i(neg),
    .link_event_i(ev), .link_indicator_pin_o(pin), .activity_indicator_o(act),
    .auto_crossover_o(ax), .force_crossover_o(fx), .pause_rx_o(prx), .pause_tx_o(ptx),
    .mgmt_addr_o(maddr), .irq_o(irq));
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] i, input logic [15:0] d, input logic [1:0] s);
    @(posedge sys_clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {16'h0, d};
    sel <= {2'h0, s};
    @(posedge sys_clk_i);
    while (ack !== 1'h1 && err !== 1'h1) @(posedge sys_clk_i);
    q = rdat;
    e = err;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task run(input logic v);
    n = 0;
    while (act === v && n < 2000) begin
      n++;
      @(posedge sys_clk_i);
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    repeat (6) @(posedge sys_clk_i);
    xfer(1'h0, `LPC_IDX_IND_CTRL, 16'h0, 2'h3);
    chk("ind reset", 32'h400, q);
    xfer(1'h0, `LPC_IDX_PHY_CTRL, 16'h0, 2'h3);
    chk("phy reset", 32'h800b, q);
    chk("autox", 32'h1, {31'h0, ax});
    chk("forcex", 32'h0, {31'h0, fx});
    chk("addr", 32'hb, {27'h0, maddr});
    $display("reset test done");
    xfer(1'h1, `LPC_IDX_IND_CTRL, 16'hffff, 2'h3);
    xfer(1'h0, `LPC_IDX_IND_CTRL, 16'h0, 2'h3);
    chk("ind bits", 32'h692, q);
    xfer(1'h1, `LPC_IDX_PHY_CTRL, 16'hffff, 2'h3);
    xfer(1'h0, `LPC_IDX_PHY_CTRL, 16'h0, 2'h3);
    chk("phy bits", 32'hc0ab, q);
    chk("autox set", 32'h1, {31'h0, ax});
    chk("forcex set", 32'h1, {31'h0, fx});
    xfer(1'h1, `LPC_IDX_PHY_CTRL, 16'h0, 2'h3);
    repeat (2) @(posedge sys_clk_i);
    chk("autox clear", 32'h0, {31'h0, ax});
    chk("forcex clear", 32'h0, {31'h0, fx});
    xfer(1'h1, `LPC_IDX_IND_CTRL, 16'h0, 2'h3);
    xfer(1'h1, `LPC_IDX_IND_CTRL, 16'hffff, 2'h1);
    xfer(1'h0, `LPC_IDX_IND_CTRL, 16'h0, 2'h3);
    chk("ind low byte", 32'h92, q);
    $display("write test done");
    for (int k = 0; k < 5; k++) begin
      xfer(1'h1, `LPC_IDX_IND_CTRL, pv[k], 2'h3);
      repeat (3) @(posedge sys_clk_i);
      chk("link pin", {31'h0, pe[k]}, {31'h0, pin});
    end
    $display("pin test done");
    ev <= 1'h1;
    for (int r = 0; r < 4; r++) begin
      xfer(1'h1, `LPC_IDX_IND_CTRL, 16'(r) << 9, 2'h3);
      run(1'h1);
      run(1'h0);
      run(1'h1);
      chk("blink half", ms[r], n);
    end
    $display("blink test done");
    run(1'h0);
    ev <= 1'h0;
    repeat (10) @(posedge sys_clk_i);
    chk("stretch hold", 32'h1, {31'h0, act});
    xfer(1'h1, `LPC_IDX_PHY_CTRL, 16'h80, 2'h3);
    @(posedge sys_clk_i);
    chk("bypass drop", 32'h0, {31'h0, act});
    $display("stretch test done");
    for (int k = 0; k < 6; k++) begin
      neg <= nv[k];
      repeat (6) @(posedge sys_clk_i);
      chk("pause rx", {31'h0, nx[k][2]}, {31'h0, prx});
      chk("pause tx", {31'h0, nx[k][1]}, {31'h0, ptx});
      xfer(1'h0, `LPC_IDX_PHY_CTRL, 16'h0, 2'h3);
      chk("phy status", {29'h0, nx[k]}, {29'h0, q[13:11]});
    end
    $display("pause test done");
    xfer(1'h1, `LPC_IDX_MASK, 16'h1, 2'h3);
    xfer(1'h0, `LPC_IDX_STATUS, 16'h0, 2'h3);
    neg <= 8'hf5;
    repeat (6) @(posedge sys_clk_i);
    chk("irq set", 32'h1, {31'h0, irq});
    xfer(1'h0, `LPC_IDX_STATUS, 16'h0, 2'h3);
    chk("status", 32'h7, q);
    repeat (2) @(posedge sys_clk_i);
    chk("irq clear", 32'h0, {31'h0, irq});
    xfer(1'h1, `LPC_IDX_MASK, 16'h0, 2'h3);
    neg <= 8'h75;
    repeat (6) @(posedge sys_clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'h0, 8'hff, 16'h0, 2'h3);
    chk("unmapped err", 32'h1, {31'h0, e});
    $display("irq test done");
    strap <= 8'had;
    xm <= 1'h1;
    rst_n_i <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    repeat (6) @(posedge sys_clk_i);
    xfer(1'h0, `LPC_IDX_IND_CTRL, 16'h0, 2'h3);
    chk("ext ind", 32'h480, q);
    xfer(1'h0, `LPC_IDX_PHY_CTRL, 16'h0, 2'h3);
    chk("ext phy", 32'h4015, q);
    chk("ext autox", 32'h0, {31'h0, ax});
    chk("ext forcex", 32'h1, {31'h0, fx});
    chk("ext addr", 32'h15, {27'h0, maddr});
    chk("ext pin", 32'h0, {31'h0, pin});
    $display("strap test done");
    tally_and_finish();
  end
endmodule
